// [hdl/tde_engine.sv]
`timescale 1ns/100ps
`include "tde_defs.svh"
// Operation
// - Final flag needs end-of-frame; completes on shift
// - Marker bit raises event on descriptor read
// - HDLC ones-fill sends count-plus-one idle bytes; count zero sends none
// - D channel sends priority ones before opening
// - Without ones-fill one flag closes and opens
// - D channel honours ones-fill without end-of-frame
// - Fill count sets flags after closing flag
// - Count zero class one, one class two
// - D channel skips fill count whenever ones-fill set
// - Buffer start pointer taken, any byte alignment
// - Next-link pointer reaches next descriptor
// - Null link raises optional end-of-list event
// - After null, fill until setup or restart
// - Status written in one memory write
// - Buffer-done bit always set in status
// - Underrun flags status; HDLC aborts, transparent repeats
// - HDLC abort during data sets abort bit
// - HDLC end-of-frame appends checksum unless skipped
// - Byte count held on chip, decremented
// - At null, last fill or byte repeats
// - HDLC underrun marks descriptors through end-of-frame
module tde_engine (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Descriptor and buffer memory
    output tde_pkg::tde_memreq_t memReq,
    input wire logic memAck,
    input wire logic [31:0] memRdata,
    // Serial shifter
    output tde_pkg::tde_tx_t txOut,
    input wire logic txReady,
    // Events
    output tde_pkg::tde_evt_t evtOut
);

    tde_pkg::tde_state_t state_q;
    tde_pkg::tde_memreq_t memReq_q;
    tde_pkg::tde_tx_t tx_q;
    tde_pkg::tde_evt_t evt_q;
    logic [31:0] ctrl_q;
    logic [31:0] pipe_q;
    logic [31:0] desc_q;
    logic [31:0] word0_q;
    logic [31:0] buf_q;
    logic [31:0] next_q;
    logic [31:0] rdata_q;
    logic [12:0] cnt_q;
    logic [12:0] fillCnt_q;
    logic [7:0] hold_q;
    logic wait_q;
    logic go_q;
    logic held_q;
    logic needOpen_q;
    logic first_q;
    logic abortRun_q;
    logic underSt_q;
    logic abortSt_q;
    logic lastPend_q;

    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign memReq = memReq_q;
    assign txOut = tx_q;
    assign evtOut = evt_q;

    // Bus decode; every access answers on the second cycle
    wire logic busTake = (read | write) & wait_q;
    wire logic wrDone = write & ~wait_q;
    wire logic [31:0] beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
        {8{byteenable[1]}}, {8{byteenable[0]}}};
    wire logic wrCtrl = wrDone & (address == `TDE_REG_CTRL);
    wire logic wrPipe = wrDone & (address == `TDE_REG_PIPE);
    wire logic restartHit = wrCtrl & byteenable[0] & writedata[`TDE_CTRL_RESTART];
    wire logic setGo = wrPipe | restartHit;
    wire logic [31:0] ctrlNew = (ctrl_q & ~beMask) | (writedata & beMask);
    wire logic [31:0] pipeNew = (pipe_q & ~beMask) | (writedata & beMask);
    wire logic [31:0] statWord = {20'h00000, go_q, needOpen_q, abortRun_q,
        held_q, 4'h0, state_q};
    wire logic [31:0] rdMux =
        (address == `TDE_REG_CTRL) ? ctrl_q :
        (address == `TDE_REG_PIPE) ? pipe_q :
        (address == `TDE_REG_STAT) ? statWord :
        (address == `TDE_REG_DESC) ? desc_q : 32'h00000000;

    // Control fields
    wire logic en = ctrl_q[`TDE_CTRL_EN];
    wire logic hdlc = ctrl_q[`TDE_CTRL_HDLC];
    wire logic dch = hdlc & ctrl_q[`TDE_CTRL_DCH];
    wire logic endIe = ctrl_q[`TDE_CTRL_EOLIE];
    wire logic [4:0] chan = ctrl_q[`TDE_CTRL_CHAN];

    // Descriptor fields
    wire logic eof = word0_q[`TDE_EOF];
    wire logic noCrc = word0_q[`TDE_NOCRC];
    wire logic finalIrq = word0_q[`TDE_FINAL];
    wire logic ones = word0_q[`TDE_ONES];

    // State decode
    wire logic inData = state_q == tde_pkg::S_DATA;
    wire logic inStat = state_q == tde_pkg::S_STAT;
    wire logic inCtrl = state_q == tde_pkg::S_CTRL;
    wire logic inPrio = state_q == tde_pkg::S_PRIO;
    wire logic inFill = state_q == tde_pkg::S_FILL;
    wire logic inCrc = state_q == tde_pkg::S_CRC;
    wire logic inFlag = (state_q == tde_pkg::S_OPEN) | (state_q == tde_pkg::S_CLOSE);
    wire logic wantDesc = inCtrl | inStat | (state_q == tde_pkg::S_BUF) |
        (state_q == tde_pkg::S_NEXT);
    wire logic inFetch = wantDesc | inData;

    // Memory master
    wire logic memDone = memReq_q.req & memAck;
    wire logic memIdle = ~memReq_q.req;
    wire logic wantData = inData & ~abortRun_q & (cnt_q != 13'h0000) & ~held_q;
    wire logic issue = memIdle & (wantDesc | wantData);
    wire logic [31:0] descOff =
        (state_q == tde_pkg::S_BUF) ? `TDE_DW_BUF :
        (state_q == tde_pkg::S_NEXT) ? `TDE_DW_NEXT :
        inStat ? `TDE_DW_STAT : `TDE_DW_CTRL;
    wire logic [31:0] reqAddr = inData ? buf_q : desc_q + descOff;
    // Reserved status bits written as zero
    wire logic [31:0] stWord = (32'(underSt_q) << `TDE_ST_UNDER) |
        (32'(abortSt_q) << `TDE_ST_ABORT) | (32'h1 << `TDE_ST_DONE);
    // Byte lane picked from the low address bits
    wire logic [7:0] laneByte = memRdata[{memReq_q.addr[1:0], 3'b000} +: 8];

    // Pointer hand-off
    wire logic goOk = go_q & (pipe_q != 32'h00000000);
    wire logic useGo = goOk & (((state_q == tde_pkg::S_OFF) & en) |
        (state_q == tde_pkg::S_NULL) | (inStat & memDone));

    // Shifter feed; a stale data byte at a take during a fetch state is an underrun
    wire logic slotFree = ~tx_q.valid | txReady;
    wire logic underrunHit = txReady & ~tx_q.valid & inFetch & ~abortRun_q &
        (tx_q.kind == tde_pkg::K_DATA);
    wire logic abortLoad = underrunHit & hdlc;
    // Only an abort blocks; a transparent underrun still loads a waiting byte
    wire logic loadOk = slotFree & ~abortLoad;
    wire logic loadEn = abortLoad | (loadOk & (inPrio | inFlag | inCrc | inFill |
        (inData & held_q & ~abortRun_q)));
    wire logic idleFill = ones & ~dch;
    wire tde_pkg::tde_kind_t loadKind =
        abortLoad ? tde_pkg::K_ABORT :
        inPrio ? tde_pkg::K_PRIO :
        inFlag ? tde_pkg::K_FLAG :
        inCrc ? tde_pkg::K_CRC :
        (inFill & idleFill) ? tde_pkg::K_IDLE :
        inFill ? tde_pkg::K_FLAG : tde_pkg::K_DATA;
    wire logic [7:0] prioByte = (fillCnt_q != 13'h0000) ? `TDE_PRIO2 : `TDE_PRIO1;
    wire logic [7:0] loadData =
        abortLoad ? `TDE_ABORT :
        inPrio ? prioByte :
        inFlag ? `TDE_FLAG :
        inCrc ? 8'h00 :
        (inFill & idleFill) ? `TDE_IDLE :
        inFill ? `TDE_FLAG : hold_q;

    // Events
    wire logic evMark = inCtrl & memDone & memRdata[`TDE_MARK];
    wire logic evDone = txReady & tx_q.valid & lastPend_q;
    wire logic evEnd = inStat & memDone & ~goOk & (next_q == 32'h00000000) & endIe;

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q <= ~busTake;
            if (busTake & read) begin
                rdata_q <= rdMux;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= `TDE_CTRL_RST;
            pipe_q <= 32'h00000000;
            go_q <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= ctrlNew & `TDE_CTRL_MASK;
            end
            if (wrPipe) begin
                pipe_q <= pipeNew;
            end
            // A new command wins over the one being consumed
            go_q <= setGo | (go_q & ~useGo);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            memReq_q <= '0;
        end else if (issue) begin
            memReq_q <= '{req: 1'b1, wr: inStat, addr: reqAddr, wdata: stWord};
        end else if (memDone) begin
            memReq_q.req <= 1'b0;
        end
    end

    // Valid drops after a take; the shifter then repeats its last byte
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_q <= '{valid: 1'b0, kind: tde_pkg::K_FLAG, data: `TDE_FLAG};
        end else if (loadEn) begin
            tx_q <= '{valid: 1'b1, kind: loadKind, data: loadData};
        end else if (txReady) begin
            tx_q.valid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            evt_q <= '0;
        end else begin
            evt_q.pulse[`TDE_EV_MARK] <= evMark;
            evt_q.pulse[`TDE_EV_DONE] <= evDone;
            evt_q.pulse[`TDE_EV_END] <= evEnd;
            evt_q.pulse[`TDE_EV_UNDER] <= underrunHit;
            evt_q.chan <= chan;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= tde_pkg::S_OFF;
            desc_q <= 32'h00000000;
            word0_q <= 32'h00000000;
            buf_q <= 32'h00000000;
            next_q <= 32'h00000000;
            cnt_q <= 13'h0000;
            fillCnt_q <= 13'h0000;
            hold_q <= 8'h00;
            held_q <= 1'b0;
            needOpen_q <= 1'b1;
            first_q <= 1'b1;
            abortRun_q <= 1'b0;
            underSt_q <= 1'b0;
            abortSt_q <= 1'b0;
            lastPend_q <= 1'b0;
        end else begin
            if (txReady & tx_q.valid) begin
                lastPend_q <= 1'b0;
            end
            case (state_q)
                tde_pkg::S_OFF: begin
                    if (useGo) begin
                        desc_q <= pipe_q;
                        state_q <= tde_pkg::S_CTRL;
                    end
                end
                tde_pkg::S_CTRL: begin
                    if (memDone) begin
                        word0_q <= memRdata;
                        state_q <= tde_pkg::S_BUF;
                    end
                end
                tde_pkg::S_BUF: begin
                    if (memDone) begin
                        buf_q <= memRdata;
                        state_q <= tde_pkg::S_NEXT;
                    end
                end
                tde_pkg::S_NEXT: begin
                    if (memDone) begin
                        next_q <= memRdata;
                        cnt_q <= word0_q[`TDE_BYTE_CNT];
                        fillCnt_q <= word0_q[`TDE_FILL_CNT];
                        underSt_q <= 1'b0;
                        abortSt_q <= 1'b0;
                        held_q <= 1'b0;
                        if (dch & first_q & ones) begin
                            state_q <= tde_pkg::S_PRIO;
                        end else if (hdlc & needOpen_q) begin
                            state_q <= tde_pkg::S_OPEN;
                        end else begin
                            state_q <= tde_pkg::S_DATA;
                        end
                    end
                end
                tde_pkg::S_PRIO: begin
                    if (loadOk) begin
                        state_q <= tde_pkg::S_OPEN;
                    end
                end
                tde_pkg::S_OPEN: begin
                    if (loadOk) begin
                        needOpen_q <= 1'b0;
                        state_q <= tde_pkg::S_DATA;
                    end
                end
                tde_pkg::S_DATA: begin
                    if (abortRun_q) begin
                        // Wait out a late fetch so it is not taken as the status ack
                        if (memIdle) begin
                            underSt_q <= 1'b1;
                            abortRun_q <= ~eof;
                            state_q <= eof ? tde_pkg::S_CLOSE : tde_pkg::S_STAT;
                        end
                    end else begin
                        if (memDone) begin
                            hold_q <= laneByte;
                            held_q <= 1'b1;
                            buf_q <= buf_q + 32'h00000001;
                        end
                        if (held_q & loadOk) begin
                            held_q <= 1'b0;
                            cnt_q <= cnt_q - 13'h0001;
                            lastPend_q <= (cnt_q == 13'h0001) & eof & finalIrq;
                        end
                        if ((cnt_q == 13'h0000) & ~held_q & memIdle) begin
                            if (~hdlc | ~eof) begin
                                state_q <= tde_pkg::S_STAT;
                            end else begin
                                state_q <= noCrc ? tde_pkg::S_CLOSE : tde_pkg::S_CRC;
                            end
                        end
                    end
                end
                tde_pkg::S_CRC: begin
                    if (loadOk) begin
                        state_q <= tde_pkg::S_CLOSE;
                    end
                end
                tde_pkg::S_CLOSE: begin
                    if (loadOk) begin
                        // Idles destroy the shared flag, so reopen afterwards
                        needOpen_q <= idleFill & (fillCnt_q != 13'h0000);
                        if (~ones) begin
                            fillCnt_q <= fillCnt_q - 13'h0001;
                        end
                        if ((fillCnt_q == 13'h0000) | (dch & ones)) begin
                            state_q <= tde_pkg::S_STAT;
                        end else begin
                            state_q <= tde_pkg::S_FILL;
                        end
                    end
                end
                tde_pkg::S_FILL: begin
                    if (loadOk) begin
                        if (fillCnt_q == 13'h0000) begin
                            state_q <= tde_pkg::S_STAT;
                        end else begin
                            fillCnt_q <= fillCnt_q - 13'h0001;
                        end
                    end
                end
                tde_pkg::S_STAT: begin
                    if (memDone) begin
                        first_q <= eof;
                        if (useGo) begin
                            desc_q <= pipe_q;
                            state_q <= tde_pkg::S_CTRL;
                        end else if (next_q != 32'h00000000) begin
                            desc_q <= next_q;
                            state_q <= tde_pkg::S_CTRL;
                        end else begin
                            needOpen_q <= 1'b1;
                            first_q <= 1'b1;
                            state_q <= tde_pkg::S_NULL;
                        end
                    end
                end
                tde_pkg::S_NULL: begin
                    if (useGo) begin
                        desc_q <= pipe_q;
                        state_q <= tde_pkg::S_CTRL;
                    end
                end
                default: begin
                    state_q <= tde_pkg::S_OFF;
                end
            endcase
            if (underrunHit) begin
                underSt_q <= 1'b1;
                abortSt_q <= abortSt_q | (hdlc & inData);
                abortRun_q <= hdlc;
            end
        end
    end

endmodule : tde_engine

// [pkg/tde_defs.svh]
`ifndef TDE_DEFS_SVH
`define TDE_DEFS_SVH
// Register byte offsets
`define TDE_REG_CTRL 4'h0
`define TDE_REG_PIPE 4'h4
`define TDE_REG_STAT 4'h8
`define TDE_REG_DESC 4'hC
// Control register fields
`define TDE_CTRL_EN 0
`define TDE_CTRL_HDLC 1
`define TDE_CTRL_DCH 2
`define TDE_CTRL_EOLIE 3
`define TDE_CTRL_RESTART 4
`define TDE_CTRL_CHAN 12:8
`define TDE_CTRL_MASK 32'h00001F0F
`define TDE_CTRL_RST 32'h00000000
// Descriptor word offsets
`define TDE_DW_CTRL 32'h00000000
`define TDE_DW_BUF 32'h00000004
`define TDE_DW_NEXT 32'h00000008
`define TDE_DW_STAT 32'h0000000C
// Descriptor control word fields
`define TDE_EOF 31
`define TDE_NOCRC 30
`define TDE_BYTE_CNT 28:16
`define TDE_FINAL 15
`define TDE_MARK 14
`define TDE_ONES 13
`define TDE_FILL_CNT 12:0
// Descriptor status bits
`define TDE_ST_UNDER 3
`define TDE_ST_ABORT 2
`define TDE_ST_DONE 0
// Fill and marker bytes
`define TDE_FLAG 8'h7E
`define TDE_IDLE 8'hFF
`define TDE_ABORT 8'h7F
`define TDE_PRIO1 8'h08
`define TDE_PRIO2 8'h0A
// Event pulse positions
`define TDE_EV_MARK 0
`define TDE_EV_DONE 1
`define TDE_EV_END 2
`define TDE_EV_UNDER 3
`endif

// [pkg/tde_pkg.sv]
package tde_pkg;
    typedef enum logic [3:0] {
        S_OFF = 4'h0, S_CTRL = 4'h1, S_BUF = 4'h2, S_NEXT = 4'h3,
        S_PRIO = 4'h4, S_OPEN = 4'h5, S_DATA = 4'h6, S_CRC = 4'h7,
        S_CLOSE = 4'h8, S_FILL = 4'h9, S_STAT = 4'hA, S_NULL = 4'hB
    } tde_state_t;
    typedef enum logic [2:0] {
        K_DATA = 3'h0, K_FLAG = 3'h1, K_IDLE = 3'h2,
        K_CRC = 3'h3, K_ABORT = 3'h4, K_PRIO = 3'h5
    } tde_kind_t;
    typedef struct packed {
        logic req;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } tde_memreq_t;
    typedef struct packed {
        logic valid;
        tde_kind_t kind;
        logic [7:0] data;
    } tde_tx_t;
    typedef struct packed {
        logic [3:0] pulse;
        logic [4:0] chan;
    } tde_evt_t;
endpackage : tde_pkg

// [verif/tb.sv]
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] readdata;
    logic waitrequest;
    tde_pkg::tde_memreq_t memReq;
    logic memAck;
    logic [31:0] memRdata;
    tde_pkg::tde_tx_t txOut;
    logic txReady = 1'b0;
    tde_pkg::tde_evt_t evtOut;
    logic [7:0] lat = 8'h02;
    // Slower than one byte fetch, so framed tests never starve
    int gap = 8;
    int cyc = 0;
    int n_fail = 0;
    int compares = 0;
    int ev [4] = '{0, 0, 0, 0};
    logic [10:0] seen [$];
    logic [31:0] rd;

    tde_engine u_tde_engine (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .memReq(memReq), .memAck(memAck), .memRdata(memRdata),
        .txOut(txOut), .txReady(txReady), .evtOut(evtOut));
    tde_mem_model u_tde_mem_model (.clk(clk), .rst(rst), .memReq(memReq), .memAck(memAck),
        .memRdata(memRdata), .lat(lat));

    always #12.5 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        txReady <= (cyc % gap == 0);
        if (txReady && txOut.valid === 1'b1) begin
            seen.push_back({txOut.kind, txOut.data});
        end
        for (int i = 0; i < 4; i++) begin
            if (!rst && evtOut.pulse[i] === 1'b1) begin
                ev[i]++;
            end
        end
        if (cyc > 40000) begin
            n_fail++;
            end_sim();
        end
    end

    function logic [7:0] bx(input int a);
        return 8'(a) ^ 8'h5A;
    endfunction : bx

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task do_reset();
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 64; k++) begin
            u_tde_mem_model.mem[k] = k < 32 ? 32'h0 : {bx(4*k+3), bx(4*k+2), bx(4*k+1), bx(4*k)};
        end
        seen.delete();
        ev = '{0, 0, 0, 0};
    endtask : do_reset

    task desc(input int a, input logic [31:0] c, input logic [31:0] b, input logic [31:0] n);
        u_tde_mem_model.mem[a / 4] = c;
        u_tde_mem_model.mem[a / 4 + 1] = b;
        u_tde_mem_model.mem[a / 4 + 2] = n;
        u_tde_mem_model.mem[a / 4 + 3] = 32'h0;
    endtask : desc

    task start(input logic [31:0] p, input logic [31:0] c);
        bus(1'b1, 4'h4, p);
        bus(1'b1, 4'h0, c | 32'h10);
    endtask : start

    task wait_stat(input int a);
        while (u_tde_mem_model.mem[a / 4 + 3] === 32'h0) begin
            @(posedge clk);
        end
    endtask : wait_stat

    task end_sim();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    initial begin : main
        int nd;
        int ni;
        int np;
        logic [7:0] xb [5];
        do_reset();
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 4'h2, 32'hFFFFFFFF);
        bus(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 4'h0, 32'h0000051A);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0000050A);
        $display("test regs done");
        // Idle fill, reopened flag after idles, skipped checksum, null link
        desc(32'h40, 32'h8003E002, 32'h81, 32'h50);
        desc(32'h50, 32'hC0020001, 32'h86, 32'h0);
        start(32'h40, 32'h0000050B);
        while (ev[2] < 1) begin
            @(posedge clk);
        end
        repeat (20) @(posedge clk);
        chk(32'(seen[$][10:8]), 32'(tde_pkg::K_FLAG));
        xb = '{bx(32'h81), bx(32'h82), bx(32'h83), bx(32'h86), bx(32'h87)};
        nd = 0;
        ni = 0;
        foreach (seen[i]) begin
            if (seen[i][10:8] == tde_pkg::K_DATA) begin
                chk(32'(seen[i][7:0]), 32'(xb[nd]));
                nd++;
                if (nd == 3) chk(32'(seen[i + 1][10:8]), 32'(tde_pkg::K_CRC));
                if (nd == 5) chk(32'(seen[i + 1][10:8]), 32'(tde_pkg::K_FLAG));
            end
            ni += int'(seen[i][10:8] == tde_pkg::K_IDLE);
        end
        chk(32'(nd), 32'h5);
        chk(32'(ni), 32'h3);
        chk(32'(ev[0]), 32'h1);
        chk(32'(ev[1]), 32'h1);
        chk(32'(ev[2]), 32'h1);
        chk(u_tde_mem_model.mem[19], 32'h1);
        chk(u_tde_mem_model.mem[23], 32'h1);
        seen.delete();
        desc(32'h60, 32'h80012000, 32'h90, 32'h0);
        bus(1'b1, 4'h4, 32'h60);
        wait_stat(32'h60);
        foreach (seen[i]) begin
            if (seen[i][10:8] == tde_pkg::K_DATA) chk(32'(seen[i][7:0]), 32'(bx(32'h90)));
        end
        chk(u_tde_mem_model.mem[27], 32'h1);
        $display("test chain done");
        for (int f = 0; f < 2; f++) begin
            do_reset();
            desc(32'h40, 32'h80012000 | f, 32'h81, 32'h0);
            start(32'h40, 32'h00000007);
            wait_stat(32'h40);
            np = 0;
            foreach (seen[i]) begin
                if (seen[i][10:8] == tde_pkg::K_PRIO && np++ == 0) begin
                    chk(32'(seen[i][7:0]), f ? 32'hA : 32'h8);
                    chk(32'(seen[i + 1][10:8]), 32'(tde_pkg::K_FLAG));
                end
            end
            chk(32'(np), 32'h1);
        end
        $display("test priority done");
        // Slow memory starves the shifter in both modes
        for (int m = 0; m < 2; m++) begin
            do_reset();
            lat <= 8'h1E;
            gap <= 1;
            desc(32'h40, 32'h80042000, 32'h81, 32'h0);
            start(32'h40, m ? 32'h1 : 32'h3);
            wait_stat(32'h40);
            chk(u_tde_mem_model.mem[19], m ? 32'h9 : 32'hD);
            chk(32'(ev[3] > 0), 32'h1);
            chk(32'(ev[2]), 32'h0);
        end
        $display("test underrun done");
        end_sim();
    end
endmodule : tb

// [verif/tde_engine_sva.sv]
`timescale 1ns/100ps
`include "tde_defs.svh"
module tde_engine_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Memory and shifter
    input wire tde_pkg::tde_memreq_t memReq,
    input wire logic memAck,
    input wire logic [31:0] memRdata,
    input wire tde_pkg::tde_tx_t txOut,
    input wire logic txReady,
    // Events
    input wire tde_pkg::tde_evt_t evtOut
);
    logic [31:0] cfg_q;
    wire ctrlWr = write && !waitrequest && address == `TDE_REG_CTRL;
    wire statWr = memReq.req && memReq.wr;
    wire statAck = memAck && memReq.wr;
    wire markAck = memAck && memRdata[`TDE_MARK];
    wire missTake = txReady && !txOut.valid;
    wire takeData = txReady && txOut.valid && txOut.kind == tde_pkg::K_DATA;

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= 32'h0;
        end else if (ctrlWr) begin
            cfg_q <= writedata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer missed its slot");
    AST_WAIT_BACK: assert property (!waitrequest |=> waitrequest)
        else $error("wait release longer than one cycle");
    AST_UNMAPPED: assert property (read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_MEM_HOLD: assert property (memReq.req && !memAck |=> $stable(memReq))
        else $error("memory request changed before ack");
    AST_STAT_WORD: assert property (statWr |-> memReq.addr[3:0] == 4'hC && memReq.wdata[0]
        && memReq.wdata[31:4] == 28'h0 && !memReq.wdata[1]) else $error("bad status write");
    AST_ABORT_HDLC: assert property (statWr && !cfg_q[1] |-> !memReq.wdata[2])
        else $error("abort bit outside framed mode");
    AST_MARK: assert property (evtOut.pulse[0] |-> $past(markAck))
        else $error("marker event without marked word");
    AST_DONE: assert property (evtOut.pulse[1] |-> $past(takeData))
        else $error("complete event without data take");
    AST_LIST_END: assert property (evtOut.pulse[2] |-> $past(statAck) && cfg_q[3])
        else $error("end of list event misplaced");
    AST_UNDER: assert property (evtOut.pulse[3] |-> $past(missTake))
        else $error("underrun event without missed take");
    AST_CHAN: assert property (evtOut.pulse != 4'h0 |-> evtOut.chan == cfg_q[12:8])
        else $error("event channel wrong");
    AST_PRIO: assert property (txOut.valid && txOut.kind == tde_pkg::K_PRIO |-> cfg_q[2]
        && (txOut.data == `TDE_PRIO1 || txOut.data == `TDE_PRIO2)) else $error("bad priority run");

    cover property (evtOut.pulse[0]);
    cover property (evtOut.pulse[2]);
    cover property (evtOut.pulse[3]);
endmodule : tde_engine_sva

bind tde_engine tde_engine_sva u_tde_engine_sva (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .memReq(memReq), .memAck(memAck), .memRdata(memRdata),
    .txOut(txOut), .txReady(txReady), .evtOut(evtOut));

// [verif/tde_mem_model.sv]
`timescale 1ns/100ps
module tde_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Memory port
    input wire tde_pkg::tde_memreq_t memReq,
    output logic memAck,
    output logic [31:0] memRdata,
    // Answer delay in cycles
    input wire logic [7:0] lat
);
    logic [31:0] mem [0:63];
    logic [7:0] cnt_q = 8'h00;
    logic [31:0] word_q = 32'h0;

    // Off-ack data inverted so a stale word never passes
    assign memRdata = memAck ? word_q : ~word_q;

    initial memAck = 1'b0;

    always @(posedge clk) begin
        memAck <= 1'b0;
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (memReq.req && !memAck) begin
            if (cnt_q >= lat) begin
                cnt_q <= 8'h00;
                memAck <= 1'b1;
                word_q <= mem[memReq.addr[7:2]];
                if (memReq.wr) begin
                    mem[memReq.addr[7:2]] <= memReq.wdata;
                end
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule : tde_mem_model
